// ===== core/smbus_charger_device.sv
// Summary of operation
// - Input limit DAC uses bits 7..12
// - DAC bits weigh 256 mA upward, doubling
// - Effective input limit clamps at 11.004 A
// - Requests under 256 mA give zero
// - Input limit resets to 256 mA
// - Input limit at code 0x3F, readable
// - Register LSB is 20 uV, 2 mA
// - Over input limit, charge current backs off
// - 175 s without setpoint write stops charging
// - SCL low over 25 ms stops charging
// - Setpoint write re-enables after timeout
// - Registers 16 bits, two bytes each
// - Low byte first, high byte second
// - Write: address, code, low, high, Stop
// - New setpoint takes effect at Stop
// - One register per write transaction
// - Read: select code, Stop, Start, read address
// - Read: host acks low, nacks high
// - One register per read transaction
// - Five readable internal registers
// - Charge current setpoint at code 0x14
// - Charge voltage setpoint at code 0x15
// - Enable needs current>0x7F and voltage>0x0F
module smbus_charger_device #(
   parameter logic [6:0] OWN_ADDR = chg_pkg::SLAVE_ADDR,
   parameter longint unsigned WDOG_CYC = chg_pkg::CHG_WDOG_CYC,
   parameter longint unsigned SCL_LOW_CYC = chg_pkg::SCL_LOW_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link
   smbus_if.dev bus,
   // Sense input, in 2 mA steps
   input wire logic [15:0] input_sense_code,
   // Regulation outputs
   output logic [chg_pkg::DAC_W-1:0] input_limit_dac_field,
   output logic [13:0] input_limit_ma,
   output logic [chg_pkg::DAC_W-1:0] charge_current_dac,
   output logic [chg_pkg::VDAC_W-1:0] charge_voltage_dac,
   output logic charge_enable,
   output logic charge_reduce,
   output logic wdog_timeout,
   output logic scl_timeout
);
   import chg_pkg::*;

   // ***************************************
   // Pin synchronisers and edge detect
   // ***************************************
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   always_ff @(posedge clk) begin
      if (srst) begin
         scl_sync_q <= 2'b11;
         sda_sync_q <= 2'b11;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], bus.scl};
         sda_sync_q <= {sda_sync_q[0], bus.sda};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   assign scl_s = scl_sync_q[1];
   assign sda_s = sda_sync_q[1];
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // ***************************************
   // Byte engine
   // ***************************************
   dev_state_e state_q;
   logic [3:0] bcnt_q;
   logic [2:0] byte_n_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic [15:0] wbuf_q;
   logic read_q;
   logic more_q;
   logic sda_oe_q;
   logic [15:0] cur_q;
   logic [15:0] volt_q;
   logic [15:0] inlim_q;
   logic [15:0] rd_word;
   logic commit;

   // Exactly two data bytes must arrive; a third gets no ack and voids the write at Stop
   assign commit = stop_det & ~read_q & (byte_n_q == 3'd4);

   always_comb begin
      case (ptr_q)
         REG_CHG_CURRENT: rd_word = cur_q;
         REG_CHG_VOLTAGE: rd_word = volt_q;
         REG_INPUT_LIMIT: rd_word = inlim_q;
         REG_MFR_ID: rd_word = MFR_ID_VAL;
         REG_DEV_ID: rd_word = DEV_ID_VAL;
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= D_IDLE;
         bcnt_q <= 4'h0;
         byte_n_q <= 3'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         wbuf_q <= 16'h0000;
         read_q <= 1'b0;
         more_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         state_q <= D_RX;
         bcnt_q <= 4'h0;
         byte_n_q <= 3'h0;
         read_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         state_q <= D_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (state_q)
            D_RX: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bcnt_q <= bcnt_q + 4'h1;
               end else if (scl_fall && bcnt_q == 4'h8) begin
                  byte_n_q <= byte_n_q + 3'h1;
                  state_q <= D_RXACK;
                  sda_oe_q <= 1'b1;
                  case (byte_n_q)
                     3'h0: begin
                        read_q <= shift_q[0];
                        if (shift_q[7:1] != OWN_ADDR) begin
                           state_q <= D_IDLE;
                           sda_oe_q <= 1'b0;
                        end
                     end
                     3'h1: ptr_q <= shift_q;
                     3'h2: wbuf_q[7:0] <= shift_q;
                     3'h3: wbuf_q[15:8] <= shift_q;
                     default: begin
                        state_q <= D_IDLE;
                        sda_oe_q <= 1'b0;
                     end
                  endcase
               end
            end
            D_RXACK: begin
               if (scl_fall) begin
                  bcnt_q <= 4'h0;
                  if (read_q) begin
                     shift_q <= rd_word[7:0];
                     sda_oe_q <= ~rd_word[7];
                     state_q <= D_TX;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q <= D_RX;
                  end
               end
            end
            D_TX: begin
               if (scl_rise) begin
                  bcnt_q <= bcnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (bcnt_q == 4'h8) begin
                     sda_oe_q <= 1'b0;
                     state_q <= D_TXACK;
                  end else begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sda_oe_q <= ~shift_q[6];
                  end
               end
            end
            D_TXACK: begin
               if (scl_rise) begin
                  // Only the low byte may be followed by more data
                  more_q <= ~sda_s & (byte_n_q == 3'h1);
               end else if (scl_fall) begin
                  bcnt_q <= 4'h0;
                  byte_n_q <= byte_n_q + 3'h1;
                  if (more_q) begin
                     shift_q <= rd_word[15:8];
                     sda_oe_q <= ~rd_word[15];
                     state_q <= D_TX;
                  end else begin
                     state_q <= D_IDLE;
                  end
               end
            end
            default: sda_oe_q <= 1'b0;
         endcase
      end
   end

   assign bus.sda_o_d = 1'b0;
   assign bus.sda_oe_d = sda_oe_q;

   // ***************************************
   // Setpoint registers
   // ***************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_q <= CHG_RESET;
         volt_q <= CHG_RESET;
         inlim_q <= INLIM_RESET;
      end else if (commit) begin
         if (ptr_q == REG_CHG_CURRENT) cur_q <= wbuf_q;
         if (ptr_q == REG_CHG_VOLTAGE) volt_q <= wbuf_q;
         if (ptr_q == REG_INPUT_LIMIT) inlim_q <= wbuf_q;
      end
   end

   // ***************************************
   // Timeouts
   // ***************************************
   logic [35:0] wdog_cnt_q;
   logic [31:0] scl_cnt_q;
   logic wdog_to_q;
   logic scl_to_q;
   logic setpt_wr;

   assign setpt_wr = commit & (ptr_q == REG_CHG_CURRENT || ptr_q == REG_CHG_VOLTAGE);

   always_ff @(posedge clk) begin
      if (srst || setpt_wr) begin
         wdog_cnt_q <= 36'h0;
      end else if (wdog_cnt_q != 36'(WDOG_CYC)) begin
         wdog_cnt_q <= wdog_cnt_q + 36'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || scl_s) begin
         scl_cnt_q <= 32'h0;
      end else if (scl_cnt_q != 32'(SCL_LOW_CYC) + 32'h1) begin
         scl_cnt_q <= scl_cnt_q + 32'h1;
      end
   end

   // A timeout in the same cycle as a setpoint write still stands
   always_ff @(posedge clk) begin
      if (srst) begin
         wdog_to_q <= 1'b0;
         scl_to_q <= 1'b0;
      end else begin
         if (wdog_cnt_q == 36'(WDOG_CYC) - 36'h1) wdog_to_q <= 1'b1;
         else if (setpt_wr) wdog_to_q <= 1'b0;
         if (scl_cnt_q == 32'(SCL_LOW_CYC)) scl_to_q <= 1'b1;
         else if (setpt_wr) scl_to_q <= 1'b0;
      end
   end

   // ***************************************
   // Setpoint decode and regulation outputs
   // ***************************************
   logic [13:0] lim_raw_ma;
   logic [13:0] lim_ma;
   assign lim_raw_ma = {inlim_q[INLIM_POS +: DAC_W], 8'h00};
   // Under 256 mA the field is zero, so the setting is zero as well
   assign lim_ma = (lim_raw_ma > INLIM_MAX_MA) ? INLIM_MAX_MA : lim_raw_ma;

   always_ff @(posedge clk) begin
      if (srst) begin
         input_limit_dac_field <= '0;
         input_limit_ma <= 14'h0;
         charge_current_dac <= '0;
         charge_voltage_dac <= '0;
         charge_enable <= 1'b0;
         charge_reduce <= 1'b0;
         wdog_timeout <= 1'b0;
         scl_timeout <= 1'b0;
      end else begin
         input_limit_dac_field <= inlim_q[INLIM_POS +: DAC_W];
         input_limit_ma <= lim_ma;
         charge_current_dac <= cur_q[CUR_POS +: DAC_W];
         charge_voltage_dac <= volt_q[VOLT_POS +: VDAC_W];
         charge_enable <= (cur_q > CUR_EN_MIN) && (volt_q > VOLT_EN_MIN)
            && !wdog_to_q && !scl_to_q;
         // Sense code is in 2 mA steps, so halve the limit in mA
         charge_reduce <= input_sense_code > {3'h0, input_limit_ma[13:1]};
         wdog_timeout <= wdog_to_q;
         scl_timeout <= scl_to_q;
      end
   end
endmodule

// ===== core/smbus_host_ctrl.sv
module smbus_host_ctrl #(
   parameter logic [6:0] DEV_ADDR = chg_pkg::SLAVE_ADDR,
   parameter int unsigned QUARTER = chg_pkg::SCL_QUARTER_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Link
   smbus_if.host bus
);
   import chg_pkg::*;

   // ***************************************
   // Bus slave
   // ***************************************
   logic wr_ph_q;
   logic [3:0] wa_q;
   logic [7:0] code_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic rd_op_q;
   logic nack_q;
   logic go;
   host_state_e st_q;
   logic busy;

   assign busy = (st_q != H_IDLE);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign go = wr_ph_q && wa_q == HOST_CTRL && hwdata[CTRL_GO] && !busy;

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ph_q <= 1'b0;
         wa_q <= 4'h0;
         hrdata <= 32'h0;
      end else if (hready) begin
         wr_ph_q <= hsel && htrans == HTRANS_NONSEQ && hwrite;
         wa_q <= haddr[3:0];
         case (haddr[3:0])
            HOST_CTRL: hrdata <= {16'h0, code_q, 6'h0, rd_op_q, 1'b0};
            HOST_WDATA: hrdata <= {16'h0, wdata_q};
            HOST_STATUS: hrdata <= {30'h0, nack_q, busy};
            HOST_RDATA: hrdata <= {16'h0, rdata_q};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         code_q <= 8'h00;
         rd_op_q <= 1'b0;
         wdata_q <= 16'h0000;
      end else if (wr_ph_q && !busy) begin
         if (wa_q == HOST_CTRL) begin
            code_q <= hwdata[CTRL_CODE_LSB +: 8];
            rd_op_q <= hwdata[CTRL_READ];
         end
         if (wa_q == HOST_WDATA) wdata_q <= hwdata[15:0];
      end
   end

   // ***************************************
   // Link sequencer: quarter-bit ticks
   // ***************************************
   logic [15:0] qcnt_q;
   logic [1:0] q_q;
   logic tick;
   logic [3:0] bit_q;
   logic [1:0] idx_q;
   logic phase_q;
   logic [7:0] tx_byte;
   logic rx_byte;
   logic [7:0] sh_q;
   logic scl_drv_q;
   logic sda_drv_q;
   logic [1:0] sda_sync_q;
   logic last_byte;

   assign tick = (qcnt_q == 16'(QUARTER - 1));
   // In the read phase only the address byte is sent by the host
   assign rx_byte = phase_q && idx_q != 2'd0;
   assign last_byte = rd_op_q ? (phase_q ? idx_q == 2'd2 : idx_q == 2'd1) : idx_q == 2'd3;

   always_comb begin
      case (idx_q)
         2'd0: tx_byte = {DEV_ADDR, phase_q};
         2'd1: tx_byte = code_q;
         2'd2: tx_byte = wdata_q[7:0];
         default: tx_byte = wdata_q[15:8];
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) sda_sync_q <= 2'b11;
      else sda_sync_q <= {sda_sync_q[0], bus.sda};
   end

   always_ff @(posedge clk) begin
      if (srst || !busy || tick) qcnt_q <= 16'h0;
      else qcnt_q <= qcnt_q + 16'h1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= H_IDLE;
         q_q <= 2'd0;
         bit_q <= 4'h0;
         idx_q <= 2'd0;
         phase_q <= 1'b0;
         sh_q <= 8'h00;
         scl_drv_q <= 1'b0;
         sda_drv_q <= 1'b0;
         nack_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else if (st_q == H_IDLE) begin
         if (go) begin
            st_q <= H_START;
            q_q <= 2'd0;
            idx_q <= 2'd0;
            phase_q <= 1'b0;
            nack_q <= 1'b0;
         end
      end else if (tick) begin
         q_q <= q_q + 2'd1;
         case (st_q)
            H_START: begin
               case (q_q)
                  2'd0: sda_drv_q <= 1'b0;
                  2'd1: scl_drv_q <= 1'b0;
                  2'd2: sda_drv_q <= 1'b1;
                  default: begin
                     scl_drv_q <= 1'b1;
                     st_q <= H_BITS;
                     bit_q <= 4'h0;
                     sh_q <= tx_byte;
                  end
               endcase
            end
            H_BITS: begin
               case (q_q)
                  2'd0: begin
                     if (bit_q == 4'h8) sda_drv_q <= rx_byte && !last_byte;
                     else sda_drv_q <= !rx_byte && !sh_q[7];
                  end
                  2'd1: scl_drv_q <= 1'b0;
                  2'd2: begin
                     if (bit_q == 4'h8 && !rx_byte && sda_sync_q[1]) nack_q <= 1'b1;
                     if (bit_q != 4'h8) sh_q <= {sh_q[6:0], sda_sync_q[1]};
                  end
                  default: begin
                     scl_drv_q <= 1'b1;
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        bit_q <= 4'h0;
                        if (rx_byte && idx_q == 2'd1) rdata_q[7:0] <= sh_q;
                        if (rx_byte && idx_q == 2'd2) rdata_q[15:8] <= sh_q;
                        if (nack_q || last_byte) begin
                           st_q <= H_STOP;
                        end else begin
                           idx_q <= idx_q + 2'd1;
                           // Load the byte that follows the current one
                           case (idx_q)
                              2'd0: sh_q <= code_q;
                              2'd1: sh_q <= wdata_q[7:0];
                              default: sh_q <= wdata_q[15:8];
                           endcase
                        end
                     end
                  end
               endcase
            end
            default: begin
               case (q_q)
                  2'd0: sda_drv_q <= 1'b1;
                  2'd1: scl_drv_q <= 1'b0;
                  2'd2: sda_drv_q <= 1'b0;
                  default: begin
                     if (rd_op_q && !phase_q && !nack_q) begin
                        phase_q <= 1'b1;
                        idx_q <= 2'd0;
                        st_q <= H_START;
                     end else begin
                        st_q <= H_IDLE;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   assign bus.scl_o_h = 1'b0;
   assign bus.scl_oe_h = scl_drv_q;
   assign bus.sda_o_h = 1'b0;
   assign bus.sda_oe_h = sda_drv_q;
endmodule

// ===== inc/chg_pkg.sv
package chg_pkg;
   // ***************************************
   // Clock and timing
   // ***************************************
   localparam longint unsigned CLK_HZ = 40_000_000;
   localparam longint unsigned CHG_WDOG_S = 175;
   localparam longint unsigned CHG_WDOG_CYC = CHG_WDOG_S * CLK_HZ;
   localparam longint unsigned SCL_LOW_US = 25_000;
   localparam longint unsigned SCL_LOW_CYC = (SCL_LOW_US * CLK_HZ) / 1_000_000;
   localparam int unsigned SCL_QUARTER_CYC = 100;

   // ***************************************
   // Register codes on the link
   // ***************************************
   localparam logic [7:0] REG_CHG_CURRENT = 8'h14;
   localparam logic [7:0] REG_CHG_VOLTAGE = 8'h15;
   localparam logic [7:0] REG_INPUT_LIMIT = 8'h3F;
   localparam logic [7:0] REG_MFR_ID = 8'hFE;
   localparam logic [7:0] REG_DEV_ID = 8'hFF;
   // Identity values are arbitrary
   localparam logic [15:0] MFR_ID_VAL = 16'h5A5A;
   localparam logic [15:0] DEV_ID_VAL = 16'h0101;
   localparam logic [6:0] SLAVE_ADDR = 7'h2A;

   // ***************************************
   // Field layout and reset values
   // ***************************************
   localparam logic [15:0] CHG_RESET = 16'h0000;
   localparam logic [15:0] INLIM_RESET = 16'h0080;
   localparam int unsigned DAC_W = 6;
   localparam int unsigned VDAC_W = 11;
   localparam int unsigned INLIM_POS = 7;
   localparam int unsigned CUR_POS = 7;
   localparam int unsigned VOLT_POS = 4;
   localparam logic [13:0] INLIM_MAX_MA = 14'd11004;
   localparam int unsigned INLIM_STEP_SH = 8;
   localparam int unsigned SENSE_LSB_UV = 20;
   localparam int unsigned SENSE_LSB_MA = 2;
   localparam logic [15:0] CUR_EN_MIN = 16'h007F;
   localparam logic [15:0] VOLT_EN_MIN = 16'h000F;

   // ***************************************
   // Host controller registers (AHB-Lite)
   // ***************************************
   localparam logic [3:0] HOST_CTRL = 4'h0;
   localparam logic [3:0] HOST_WDATA = 4'h4;
   localparam logic [3:0] HOST_STATUS = 4'h8;
   localparam logic [3:0] HOST_RDATA = 4'hC;
   localparam int unsigned CTRL_GO = 0;
   localparam int unsigned CTRL_READ = 1;
   localparam int unsigned CTRL_CODE_LSB = 8;
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_NACK = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_RX = 3'b001,
      D_RXACK = 3'b011,
      D_TX = 3'b010,
      D_TXACK = 3'b110
   } dev_state_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_START = 2'b01,
      H_BITS = 2'b11,
      H_STOP = 2'b10
   } host_state_e;
endpackage

// ===== inc/smbus_if.sv
interface smbus_if;
   logic scl_o_h;
   logic scl_oe_h;
   logic sda_o_h;
   logic sda_oe_h;
   logic sda_o_d;
   logic sda_oe_d;
   logic scl;
   logic sda;

   // Open-drain wire: released lines float high through the pull-up
   assign scl = scl_oe_h ? scl_o_h : 1'b1;
   assign sda = (sda_oe_h ? sda_o_h : 1'b1) & (sda_oe_d ? sda_o_d : 1'b1);

   modport host (output scl_o_h, output scl_oe_h, output sda_o_h, output sda_oe_h,
                 input scl, input sda);
   modport dev (output sda_o_d, output sda_oe_d, input scl, input sda);
endinterface

// ===== test/smbus_charger_asserts.sv
module smbus_charger_asserts #(
   parameter longint unsigned SCL_LOW = 2000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link wires
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_oe_d,
   // Device side
   input wire logic [chg_pkg::DAC_W-1:0] input_limit_dac_field,
   input wire logic [13:0] input_limit_ma,
   input wire logic [15:0] input_sense_code,
   input wire logic charge_enable,
   input wire logic charge_reduce,
   input wire logic wdog_timeout,
   input wire logic scl_timeout
);
   timeunit 1ns;
   timeprecision 1ps;
   import chg_pkg::*;
   // *****
   // Clock-low counter
   // *****
   longint unsigned low_cnt_q;
   always_ff @(posedge clk) begin
      if (srst || scl) begin
         low_cnt_q <= 0;
      end else begin
         low_cnt_q <= low_cnt_q + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // *****
   // Properties
   // *****
   // Moving SDA under a high clock would look like a START or STOP
   a_sda_when_low: assert property ($changed(sda_oe_d) |-> !scl)
      else $error("device moved sda while scl high");
   a_idle_lines: assert property ($fell(srst) |-> scl && sda)
      else $error("link not idle after reset");
   a_limit_map: assert property (input_limit_ma == (((14'(input_limit_dac_field) << 8) >
      INLIM_MAX_MA) ? INLIM_MAX_MA : (14'(input_limit_dac_field) << 8)))
      else $error("limit in mA does not follow field");
   a_limit_max: assert property (input_limit_ma <= 14'd11004)
      else $error("limit above clamp");
   a_por_limit: assert property ($fell(srst) |-> ##[0:2] input_limit_ma == 14'd256)
      else $error("limit not 256 mA after reset");
   a_stop_on_to: assert property ((wdog_timeout || scl_timeout) [*2] |-> !charge_enable)
      else $error("charging during timeout");
   a_scl_timer: assert property ($rose(scl_timeout) |-> low_cnt_q >= SCL_LOW)
      else $error("scl timeout too early");
   a_reduce: assert property ($stable(input_sense_code) && $stable(input_limit_ma) |=>
      charge_reduce == $past(input_sense_code > 16'(input_limit_ma >> 1)))
      else $error("reduce does not follow sense");
endmodule

// ===== test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import chg_pkg::*;
   localparam int WDOG = 20000;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic [15:0] input_sense_code = 16'h0;
   logic [DAC_W-1:0] dac_field;
   logic [DAC_W-1:0] cur_dac;
   logic [VDAC_W-1:0] volt_dac;
   logic [13:0] limit_ma;
   logic chg_en, chg_red, wdog_to, scl_to;
   logic idle_to;
   logic [7:0] b1, b2;
   logic [15:0] wv[4] = '{16'h0040, 16'h41A0, 16'h0100, 16'hFFFF};
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   int nb = 0;
   smbus_if bus_if ();
   // Second link whose clock the bench holds low, for the clock-low timeout
   smbus_if idle_if ();
   always #12.5 clk = ~clk;
   smbus_host_ctrl #(.QUARTER(5)) smbus_host_ctrl_i (.clk(clk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .bus(bus_if));
   smbus_charger_device #(.WDOG_CYC(WDOG), .SCL_LOW_CYC(2000)) smbus_charger_device_i (
      .clk(clk), .srst(srst), .bus(bus_if), .input_sense_code(input_sense_code),
      .input_limit_dac_field(dac_field), .input_limit_ma(limit_ma), .charge_current_dac(cur_dac),
      .charge_voltage_dac(volt_dac), .charge_enable(chg_en), .charge_reduce(chg_red),
      .wdog_timeout(wdog_to), .scl_timeout(scl_to));
   smbus_charger_device #(.WDOG_CYC(WDOG), .SCL_LOW_CYC(2000)) smbus_charger_device_i2 (
      .clk(clk), .srst(srst), .bus(idle_if), .input_sense_code(16'h0000),
      .input_limit_dac_field(), .input_limit_ma(), .charge_current_dac(),
      .charge_voltage_dac(), .charge_enable(), .charge_reduce(), .wdog_timeout(),
      .scl_timeout(idle_to));
   smbus_charger_asserts #(.SCL_LOW(2000)) smbus_charger_asserts_i (.clk(clk), .srst(srst),
      .scl(bus_if.scl), .sda(bus_if.sda), .sda_oe_d(bus_if.sda_oe_d),
      .input_limit_dac_field(dac_field), .input_limit_ma(limit_ma),
      .input_sense_code(input_sense_code), .charge_enable(chg_en), .charge_reduce(chg_red),
      .wdog_timeout(wdog_to), .scl_timeout(scl_to));
   // *****
   // Wire sniffer: bytes two and three after each START
   // *****
   always @(negedge bus_if.sda) if (bus_if.scl === 1'b1) nb = 0;
   always @(posedge bus_if.scl) begin
      if (nb >= 9 && nb <= 16) b1 = {b1[6:0], bus_if.sda};
      if (nb >= 18 && nb <= 25) b2 = {b2[6:0], bus_if.sda};
      nb = nb + 1;
   end
   // *****
   // Tasks
   // *****
   task automatic report_and_stop();
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic [3:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {28'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic smb(input logic rd, input logic [7:0] code, input logic [15:0] wd,
                      output logic [15:0] q);
      logic [31:0] r;
      ahb(HOST_WDATA, 1'b1, {16'h0, wd}, r);
      ahb(HOST_CTRL, 1'b1, {16'h0, code, 6'h0, rd, 1'b1}, r);
      do ahb(HOST_STATUS, 1'b0, 32'h0, r); while (r[STAT_BUSY] !== 1'b0);
      chk(r[STAT_NACK], 0);
      ahb(HOST_RDATA, 1'b0, 32'h0, r);
      q = r[15:0];
   endtask
   task automatic settle(input logic [15:0] s);
      input_sense_code <= s;
      repeat (4) @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      logic [15:0] q;
      logic [13:0] f;
      {idle_if.scl_o_h, idle_if.scl_oe_h, idle_if.sda_o_h, idle_if.sda_oe_h} <= 4'h0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({dac_field, limit_ma}, {6'h01, 14'd256});
      smb(1'b1, REG_INPUT_LIMIT, 16'h0, q);
      chk(q, INLIM_RESET);
      foreach (wv[i]) begin
         f = 14'(wv[i][12:7]);
         smb(1'b0, REG_INPUT_LIMIT, wv[i], q);
         chk({b1, b2}, {REG_INPUT_LIMIT, wv[i][7:0]});
         settle(16'h0);
         chk(dac_field, f);
         chk(limit_ma, ((f << 8) > 14'd11004) ? 14'd11004 : (f << 8));
         smb(1'b1, REG_INPUT_LIMIT, 16'h0, q);
         chk({b1, b2}, {wv[i][7:0], wv[i][15:8]});
         chk(q, wv[i]);
      end
      smb(1'b0, REG_CHG_CURRENT, 16'h0080, q);
      smb(1'b0, REG_CHG_VOLTAGE, 16'h0010, q);
      settle(16'h0);
      chk({chg_en, cur_dac, volt_dac}, {1'b1, 6'h01, 11'h001});
      smb(1'b1, REG_CHG_CURRENT, 16'h0, q);
      chk(q, 16'h0080);
      smb(1'b1, REG_CHG_VOLTAGE, 16'h0, q);
      chk(q, 16'h0010);
      smb(1'b1, REG_MFR_ID, 16'h0, q);
      chk(q, MFR_ID_VAL);
      smb(1'b1, REG_DEV_ID, 16'h0, q);
      chk(q, DEV_ID_VAL);
      smb(1'b0, REG_CHG_VOLTAGE, 16'h000F, q);
      settle(16'h0);
      chk(chg_en, 0);
      smb(1'b0, REG_CHG_VOLTAGE, 16'h0010, q);
      repeat (WDOG - 200) @(posedge clk);
      chk({wdog_to, chg_en}, 2'b01);
      repeat (400) @(posedge clk);
      chk({wdog_to, chg_en}, 2'b10);
      smb(1'b0, REG_CHG_CURRENT, 16'h0080, q);
      settle(16'd5503);
      chk({wdog_to, chg_en, chg_red}, 3'b011);
      settle(16'd5502);
      chk({chg_red, scl_to}, 2'b00);
      idle_if.scl_oe_h <= 1'b1;
      repeat (1990) @(posedge clk);
      chk(idle_to, 0);
      repeat (20) @(posedge clk);
      chk(idle_to, 1);
      report_and_stop();
   end
endmodule
